// *** rtl/periph_irq_ctrl.sv ***
// peripheral request flags, enables, priority select and two time bases behind an AHB-Lite slave
// assumes the core takes a call with irq_ack_i while irq_call_o.valid is high, in the same cycle
//
// What this block does
// - conversion finish sets converter-done flag
// - call needs global, source enable, stack free
// - converter service clears flag and global enable
// - any serial condition raises serial flag
// - serial service leaves port status untouched
// - timer has separate match A/P flags
// - timer service clears its flag, global enable
// - nonvolatile write end sets its flag
// - nonvolatile service clears flag, global enable
// - time base overflow sets its flag
// - time base service clears flag, global enable
// - source select: system, system/4, sub clock
// - period is 2^(8+code) prescaled cycles
// - unimplemented bits read zero, ignore writes
// - flag rising edge wakes from low power
// - enables never gate wake; no edge, no wake
// - flags still set during low power
// - distinct vectors, fixed priority when simultaneous
// - flag stays until serviced or cleared
// - return-from-irq sets global enable again
// - requests during service still recorded
`timescale 1ns/1ps
`default_nettype none
module periph_irq_ctrl
    import irq_tb_pkg::*;
#(
    // slot 0 holds the highest priority source index
    parameter logic [NSRC*3-1:0] PRIO_ORDER = {3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0},
    parameter logic [VEC_W-1:0] VEC_BASE = VEC_BASE_DEF
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // peripheral events and sub clock enable
    input wire src_evt_t events_i,
    input wire logic sub_tick_i,
    // core sequencer side
    input wire logic stack_full_i,
    input wire logic irq_ack_i,
    input wire logic return_from_irq_i,
    input wire logic sleep_i,
    output irq_call_t irq_call_o,
    output logic wake_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] psc0_q, psc1_q, tbc0_q, tbc1_q;
    logic [NSRC-1:0] flags_q, flags_prev_q, en_q;
    logic gie_q;
    logic wake_q;
    logic dwr_q, drd_q;
    logic [7:0] daddr_q;
    logic tick0, tick1;

    // picks the highest priority pending source; bit 3 says whether any was found
    function automatic logic [3:0] pick(input logic [NSRC-1:0] pend);
        logic [3:0] r;
        logic [2:0] s;
        r = 4'h0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            s = PRIO_ORDER[3*k +: 3];
            if (pend[s]) begin
                r = {1'b1, s};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: zero wait state, always OKAY
    wire logic aphase = hsel_i & htrans_i[1] & hready_i;
    wire logic wr_psc0 = dwr_q & (daddr_q == OFS_PSC0);
    wire logic wr_psc1 = dwr_q & (daddr_q == OFS_PSC1);
    wire logic wr_tbc0 = dwr_q & (daddr_q == OFS_TBC0);
    wire logic wr_tbc1 = dwr_q & (daddr_q == OFS_TBC1);
    wire logic wr_flags = dwr_q & (daddr_q == OFS_FLAGS);
    wire logic wr_en = dwr_q & (daddr_q == OFS_ENABLES);
    wire logic wr_ctrl = dwr_q & (daddr_q == OFS_CTRL);
    wire logic [7:0] wbyte = hwdata_i[7:0];

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dwr_q <= 1'b0;
            drd_q <= 1'b0;
            daddr_q <= 8'h00;
        end else if (hready_i) begin
            dwr_q <= aphase & hwrite_i;
            drd_q <= aphase & ~hwrite_i;
            daddr_q <= {haddr_i[7:2], 2'b00};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time base configuration
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            psc0_q <= RST_PSC;
            psc1_q <= RST_PSC;
            tbc0_q <= RST_TBC;
            tbc1_q <= RST_TBC;
        end else begin
            if (wr_psc0) psc0_q <= wbyte & PSC_MASK;
            if (wr_psc1) psc1_q <= wbyte & PSC_MASK;
            if (wr_tbc0) tbc0_q <= wbyte & TBC_MASK;
            if (wr_tbc1) tbc1_q <= wbyte & TBC_MASK;
        end
    end

    tick_unit u_tick0 (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .sub_tick_i(sub_tick_i),
        .src_sel_i(psc0_q[PSC_SEL_POS +: 2]),
        .on_i(tbc0_q[TBC_ON_POS]),
        .period_i(tbc0_q[TBC_PER_POS +: 3]),
        .tick_o(tick0)
    );

    tick_unit u_tick1 (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .sub_tick_i(sub_tick_i),
        .src_sel_i(psc1_q[PSC_SEL_POS +: 2]),
        .on_i(tbc1_q[TBC_ON_POS]),
        .period_i(tbc1_q[TBC_PER_POS +: 3]),
        .tick_o(tick1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request flags; events are taken whatever the sleep state, the core clock never stops here
    logic [NSRC-1:0] set_vec;
    assign set_vec[SRC_CONV] = events_i.conv_done;
    assign set_vec[SRC_SERIAL] = |events_i.serial_cond;
    assign set_vec[SRC_MATCH_A] = events_i.match_a;
    assign set_vec[SRC_MATCH_P] = events_i.match_p;
    assign set_vec[SRC_NV] = events_i.nv_done;
    assign set_vec[SRC_TICK0] = tick0;
    assign set_vec[SRC_TICK1] = tick1;

    wire logic [NSRC-1:0] pend = flags_q & en_q;
    wire logic [3:0] sel = pick(pend);
    wire logic call_ok = gie_q & sel[3] & ~stack_full_i;
    wire logic taken = irq_ack_i & call_ok;
    // only the serviced source's flag is cleared; serial status lives in the port itself
    wire logic [NSRC-1:0] ack_clr = taken ? (NSRC'(1) << sel[2:0]) : '0;
    wire logic [NSRC-1:0] flags_base = wr_flags ? wbyte[NSRC-1:0] : flags_q;
    // a set in the same cycle as a clear wins, so no request is lost
    wire logic [NSRC-1:0] flags_d = (flags_base & ~ack_clr) | set_vec;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flags_q <= RST_FLAGS;
            flags_prev_q <= RST_FLAGS;
            en_q <= RST_EN;
        end else begin
            flags_q <= flags_d;
            flags_prev_q <= flags_q;
            if (wr_en) en_q <= wbyte[NSRC-1:0] & SRC_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // global enable: service clears it, return sets it, software may write it
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            gie_q <= RST_GIE;
        end else if (taken) begin
            gie_q <= 1'b0;
        end else if (return_from_irq_i) begin
            gie_q <= 1'b1;
        end else if (wr_ctrl) begin
            gie_q <= wbyte[CTRL_GIE_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake on a rising flag only; enables deliberately not consulted
    wire logic [NSRC-1:0] rose = flags_q & ~flags_prev_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= sleep_i & (|rose);
        end
    end

    assign wake_o = wake_q;

    // call request is a handshake, so it is combinational from the flag flops
    assign irq_call_o.valid = call_ok;
    assign irq_call_o.src = sel[2:0];
    assign irq_call_o.vector = VEC_BASE + VEC_W'(sel[2:0]) * VEC_STEP;

    ////////////////////////////////////////////////////////////////////////////
    // read mux from register flops; stack-full is a live view of the core, not a stored bit
    wire logic [7:0] ctrl_byte = (8'(stack_full_i) << CTRL_STK_POS) | (8'(gie_q) << CTRL_GIE_POS);
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        case (daddr_q)
            OFS_PSC0: rbyte = psc0_q;
            OFS_PSC1: rbyte = psc1_q;
            OFS_TBC0: rbyte = tbc0_q;
            OFS_TBC1: rbyte = tbc1_q;
            OFS_FLAGS: rbyte = {1'b0, flags_q};
            OFS_ENABLES: rbyte = {1'b0, en_q};
            OFS_CTRL: rbyte = ctrl_byte;
            default: rbyte = 8'h00;
        endcase
    end

    assign hrdata_o = drd_q ? {24'h000000, rbyte} : 32'h00000000;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence serviced_s;
        irq_ack_i && irq_call_o.valid;
    endsequence

    conv_flag_set_a: assert property (events_i.conv_done |=> flags_q[SRC_CONV])
        else $error("conversion finish did not set its flag");

    call_gating_a: assert property (irq_call_o.valid |-> gie_q && !stack_full_i
        && (flags_q[irq_call_o.src] && en_q[irq_call_o.src]))
        else $error("call raised without all enables");

    service_clear_a: assert property (serviced_s ##0 !set_vec[sel[2:0]]
        |=> !flags_q[$past(sel[2:0])] && !gie_q)
        else $error("service did not clear flag and global enable");

    serial_any_a: assert property (|events_i.serial_cond |=> flags_q[SRC_SERIAL])
        else $error("serial condition did not raise flag");

    flag_hold_a: assert property (!taken && !wr_flags |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without service or write");

    return_from_irq_gie_a: assert property (return_from_irq_i && !taken |=> gie_q)
        else $error("return did not restore global enable");

    // the flag rises one cycle after its event; sleep has to last into that cycle
    sequence nv_rise_asleep_s;
        sleep_i && set_vec[SRC_NV] && !flags_q[SRC_NV] ##1 sleep_i;
    endsequence

    wake_rise_a: assert property (nv_rise_asleep_s |=> wake_o)
        else $error("rising flag did not wake");

    // enables are not looked at: any rise while asleep wakes
    wake_any_a: assert property (sleep_i && (|rose) |=> wake_o)
        else $error("rising flag ignored while asleep");

    wake_cause_a: assert property (wake_o |-> $past(sleep_i) && $past(|rose))
        else $error("wake without a rising flag");

    record_a: assert property (!gie_q && events_i.match_p |=> flags_q[SRC_MATCH_P])
        else $error("request lost while global enable low");

    prio_pick_a: assert property (irq_call_o.valid && pend[PRIO_ORDER[2:0]]
        |-> irq_call_o.src == PRIO_ORDER[2:0])
        else $error("highest priority source not chosen");

    ////////////////////////////////////////////////////////////////////////////
    // flag sources, service side effects and bus refusals
    nv_flag_set_a: assert property (events_i.nv_done |=> flags_q[SRC_NV])
        else $error("write end did not set its flag");

    match_p_set_a: assert property (events_i.match_p |=> flags_q[SRC_MATCH_P])
        else $error("match P did not set its flag");

    tick0_flag_a: assert property (tick0 |=> flags_q[SRC_TICK0])
        else $error("time base 0 overflow did not set its flag");

    tick1_flag_a: assert property (tick1 |=> flags_q[SRC_TICK1])
        else $error("time base 1 overflow did not set its flag");

    // a flag rises only through its own event or a software write, so A and P stay apart
    flag_cause_a: assert property (!wr_flags
        |=> ((flags_q & ~$past(flags_q)) & ~$past(set_vec)) == '0)
        else $error("flag rose without its own event");

    stack_block_a: assert property (stack_full_i |-> !irq_call_o.valid)
        else $error("call raised with the stack full");

    // nothing but a service, a write or a full stack takes a standing call away
    call_stands_a: assert property (irq_call_o.valid && !irq_ack_i && !wr_flags && !wr_en && !wr_ctrl
        |=> irq_call_o.valid || stack_full_i)
        else $error("pending call vanished");

    // servicing the serial source must leave every other flag alone
    sequence serial_taken_s;
        serviced_s ##0 irq_call_o.src == 3'(SRC_SERIAL) && !wr_flags;
    endsequence

    serial_only_a: assert property (serial_taken_s
        |=> (($past(flags_q) & ~flags_q) & ~(NSRC'(1) << SRC_SERIAL)) == '0)
        else $error("serial service dropped another flag");

    sequence tick0_taken_s;
        serviced_s ##0 irq_call_o.src == 3'(SRC_TICK0) && !tick0;
    endsequence

    tick_clear_a: assert property (tick0_taken_s |=> !flags_q[SRC_TICK0] && !gie_q)
        else $error("time base service left its flag");

    // a software write loses only to a service or a return
    sequence gie_write_s;
        wr_ctrl && !taken && !return_from_irq_i;
    endsequence

    gie_write_a: assert property (gie_write_s |=> gie_q == $past(wbyte[CTRL_GIE_POS]))
        else $error("global enable write lost");

    read_upper_a: assert property (hrdata_o[31:8] == 24'h000000 && (drd_q || hrdata_o == 32'h00000000))
        else $error("read data outside its phase or field");

    // unmapped offsets are refused silently: no configuration bit may move
    unmapped_wr_a: assert property (dwr_q && daddr_q > OFS_CTRL
        |=> $stable({psc0_q, psc1_q, tbc0_q, tbc1_q, en_q}))
        else $error("write to an unmapped offset changed a register");

endmodule // periph_irq_ctrl
`default_nettype wire

// *** rtl/irq_tb_pkg.sv ***
// constants and carriers shared by the peripheral interrupt and time-base block
// assumes a single 125 MHz core clock and byte addresses on an AHB-Lite slave port
package irq_tb_pkg;

    // clock period, kept for documentation of derived rates
    localparam int CLK_PERIOD_NS = 8;

    // request sources, index is the bit position in the flag and enable registers
    localparam int NSRC = 7;
    localparam int SRC_CONV = 0;
    localparam int SRC_SERIAL = 1;
    localparam int SRC_MATCH_A = 2;
    localparam int SRC_MATCH_P = 3;
    localparam int SRC_NV = 4;
    localparam int SRC_TICK0 = 5;
    localparam int SRC_TICK1 = 6;

    // register byte offsets within the slave window
    localparam logic [7:0] OFS_PSC0 = 8'h00;
    localparam logic [7:0] OFS_PSC1 = 8'h04;
    localparam logic [7:0] OFS_TBC0 = 8'h08;
    localparam logic [7:0] OFS_TBC1 = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_ENABLES = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;

    // field positions and implemented-bit masks
    localparam int PSC_SEL_POS = 0;
    localparam int TBC_ON_POS = 7;
    localparam int TBC_PER_POS = 0;
    localparam int CTRL_GIE_POS = 0;
    localparam int CTRL_STK_POS = 1;
    localparam logic [7:0] PSC_MASK = 8'h03;
    localparam logic [7:0] TBC_MASK = 8'h87;
    localparam logic [6:0] SRC_MASK = 7'h7F;

    // reset values
    localparam logic [7:0] RST_PSC = 8'h00;
    localparam logic [7:0] RST_TBC = 8'h00;
    localparam logic [6:0] RST_FLAGS = 7'h00;
    localparam logic [6:0] RST_EN = 7'h00;
    localparam logic RST_GIE = 1'b0;

    // prescaler source codes; 1x is the sub clock
    localparam logic [1:0] SEL_SYS = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam int DIV4_COUNT = 4;
    localparam logic [1:0] DIV4_LAST = 2'(DIV4_COUNT - 1);

    // time-out is 2^(TB_BASE_EXP + code) prescaled cycles
    localparam int TB_BASE_EXP = 8;
    localparam int TB_CNT_W = 15;

    // core vector addresses
    localparam int VEC_W = 12;
    localparam logic [VEC_W-1:0] VEC_BASE_DEF = 12'h004;
    localparam logic [VEC_W-1:0] VEC_STEP = 12'h004;

    typedef struct packed {
        logic conv_done;
        logic [5:0] serial_cond;
        logic match_a;
        logic match_p;
        logic nv_done;
    } src_evt_t;

    typedef struct packed {
        logic valid;
        logic [2:0] src;
        logic [VEC_W-1:0] vector;
    } irq_call_t;

endpackage

// *** rtl/tick_unit.sv ***
// one time base: prescaler source select, period counter and overflow pulse
// assumes sub_tick_i is a one-cycle enable at the sub clock rate in the core clock domain
`timescale 1ns/1ps
`default_nettype none
module tick_unit
    import irq_tb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic sub_tick_i,
    input wire logic [1:0] src_sel_i,
    input wire logic on_i,
    input wire logic [2:0] period_i,
    output logic tick_o
);

    logic [1:0] div_q;
    logic [TB_CNT_W-1:0] cnt_q;
    logic tick_q;

    function automatic logic [TB_CNT_W-1:0] period_mask(input logic [2:0] p);
        return TB_CNT_W'((16'h0001 << (TB_BASE_EXP + int'(p))) - 16'h0001);
    endfunction

    wire logic div4_en = (div_q == DIV4_LAST);
    wire logic psc_en = src_sel_i[1] ? sub_tick_i : ((src_sel_i == SEL_DIV4) ? div4_en : 1'b1);
    wire logic [TB_CNT_W-1:0] mask = period_mask(period_i);
    wire logic wrap = on_i & psc_en & ((cnt_q & mask) == mask);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            div_q <= 2'h0;
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            tick_q <= wrap;
            // held cleared while off so a full period follows re-enable
            if (!on_i || wrap) begin
                cnt_q <= '0;
            end else if (psc_en) begin
                cnt_q <= cnt_q + TB_CNT_W'(1);
            end
        end
    end

    assign tick_o = tick_q;

    ////////////////////////////////////////////////////////////////////////////
    tick_idle_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !on_i |=> (cnt_q == '0) && !tick_o)
        else $error("time base counter not held while off");

    tick_sys_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        on_i && src_sel_i == SEL_SYS && period_i == 3'h0 && (cnt_q & 15'h00FF) == 15'h00FF
        |=> tick_o && cnt_q == '0)
        else $error("time base did not overflow after 256 counts");

endmodule // tick_unit
`default_nettype wire

// *** verif/core_seq_model.sv ***
// core sequencer stand-in: takes calls, keeps a stack depth, issues returns
// assumes irq_call_i is combinational from the controller's flops
`timescale 1ns/1ps
`default_nettype none
module core_seq_model
    import irq_tb_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire irq_call_t irq_call_i,
    input wire logic accept_i,
    input wire logic ret_req_i,
    output logic irq_ack_o,
    output logic return_from_irq_o,
    output logic stack_full_o,
    output irq_call_t taken_o,
    output int taken_cnt_o
);
    int depth_q;
    logic pop;
    // a slow core holds accept low, so the call has to keep standing
    assign irq_ack_o = irq_call_i.valid & accept_i;
    assign pop = ret_req_i && (depth_q > 0);
    assign stack_full_o = (depth_q >= DEPTH);
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            depth_q <= 0;
            return_from_irq_o <= 1'b0;
            taken_o <= '0;
            taken_cnt_o <= 0;
        end else begin
            return_from_irq_o <= pop;
            depth_q <= depth_q + int'(irq_ack_o) - int'(pop);
            if (irq_ack_o) begin
                taken_o <= irq_call_i;
                taken_cnt_o <= taken_cnt_o + 1;
            end
        end
    end
endmodule // core_seq_model
`default_nettype wire

// *** verif/periph_irq_ctrl_tb.sv ***
// self-checking bench for the peripheral request and time-base block
// assumes a zero-wait slave; the core model acks in the cycle a call stands while accept is high
`timescale 1ns/1ps
`default_nettype none
module periph_irq_ctrl_tb
    import irq_tb_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} reg_row_t;
    typedef struct packed {logic u; logic [1:0] sel; logic [2:0] code; int n;} tick_row_t;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hready, hresp, ack, ret, full, wake;
    src_evt_t events = '0;
    logic sub_tick = 1'b0;
    logic sleep = 1'b0;
    logic accept = 1'b1;
    logic ret_req = 1'b0;
    irq_call_t call, taken;
    int taken_cnt, n, t0;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    reg_row_t rows [15] = '{'{8'h00, 8'hFF, 8'h03}, '{8'h04, 8'hFE, 8'h02}, '{8'h08, 8'hFF, 8'h87},
        '{8'h0C, 8'h7A, 8'h02}, '{8'h14, 8'hFF, 8'h7F}, '{8'h1C, 8'hFF, 8'h00}, '{8'h18, 8'hFE, 8'h00},
        '{8'h18, 8'hFF, 8'h01}, '{8'h18, 8'h00, 8'h00}, '{8'h08, 8'h00, 8'h00}, '{8'h14, 8'h00, 8'h00},
        '{8'h10, 8'h55, 8'h55}, '{8'h10, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h00}, '{8'h04, 8'h00, 8'h00}};
    // sub clock enable fires every 4 cycles, so sub rows count 4x longer
    tick_row_t ticks [5] = '{'{1'b0, 2'h0, 3'h0, 256}, '{1'b0, 2'h0, 3'h1, 512},
        '{1'b0, 2'h1, 3'h0, 1024}, '{1'b1, 2'h2, 3'h0, 1024}, '{1'b1, 2'h3, 3'h1, 2048}};

    periph_irq_ctrl u_periph_irq_ctrl (.core_clk_i(core_clk), .srst_i(srst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .events_i(events), .sub_tick_i(sub_tick), .stack_full_i(full), .irq_ack_i(ack),
        .return_from_irq_i(ret), .sleep_i(sleep), .irq_call_o(call), .wake_o(wake));
    core_seq_model u_core_seq_model (.core_clk_i(core_clk), .srst_i(srst), .irq_call_i(call),
        .accept_i(accept), .ret_req_i(ret_req), .irq_ack_o(ack), .return_from_irq_o(ret),
        .stack_full_o(full), .taken_o(taken), .taken_cnt_o(taken_cnt));

    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sub_tick <= (cyc[1:0] == 2'h0);
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
        check("resp", 32'(hresp), 32'h0);
    endtask
    // trailing edge keeps two pulses from landing in one time step
    task automatic pulse(input src_evt_t e);
        events <= e;
        @(posedge core_clk);
        events <= '0;
        @(posedge core_clk);
    endtask
    task automatic do_ret;
        ret_req <= 1'b1;
        @(posedge core_clk);
        ret_req <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_cnt(input int c);
        for (int k = 0; k < 400 && taken_cnt != c; k++) @(posedge core_clk);
        n = c;
        check("calls", 32'(taken_cnt), 32'(c));
    endtask
    task automatic wake_win(input int exp);
        int c;
        c = 0;
        repeat (8) begin
            @(posedge core_clk);
            c += int'(wake === 1'b1);
        end
        check("wake", 32'(c), 32'(exp));
    endtask
    task automatic test_done;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int s;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 7; i++) rdchk("reset", 8'(4 * i), 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, 32'(rows[i].d));
            rdchk("reg", rows[i].a, 32'(rows[i].e));
        end
        n = 0;
        for (int i = 0; i < 10; i++) begin
            s = (i == 9) ? 0 : (i >= 3) ? 1 : 4 - i;
            bus(1'b1, OFS_ENABLES, 32'h7F);
            bus(1'b1, OFS_CTRL, 32'h01);
            pulse(src_evt_t'(10'h1 << i));
            wait_cnt(n + 1);
            check("src", 32'(taken.src), 32'(s));
            check("vector", 32'(taken.vector), 32'(VEC_BASE_DEF) + 32'(s) * 32'h4);
            rdchk("flags", OFS_FLAGS, 32'h0);
            rdchk("gie", OFS_CTRL, 32'h0);
            do_ret;
            rdchk("gie", OFS_CTRL, 32'h1);
        end
        // enables off: flags are kept, no call; then priority and stack gating
        bus(1'b1, OFS_ENABLES, 32'h0);
        pulse(src_evt_t'(10'h201));
        repeat (3) @(posedge core_clk);
        check("nocall", 32'(taken_cnt), 32'(n));
        rdchk("flags", OFS_FLAGS, 32'h11);
        accept <= 1'b0;
        bus(1'b1, OFS_ENABLES, 32'h7F);
        repeat (4) @(posedge core_clk);
        check("stands", 32'(call.valid), 32'h1);
        check("prio", 32'(call.src), 32'h0);
        accept <= 1'b1;
        wait_cnt(n + 1);
        rdchk("flags", OFS_FLAGS, 32'h10);
        bus(1'b1, OFS_CTRL, 32'h01);
        wait_cnt(n + 1);
        check("src", 32'(taken.src), 32'h4);
        pulse(src_evt_t'(10'h004));
        bus(1'b1, OFS_CTRL, 32'h01);
        rdchk("ctrl", OFS_CTRL, 32'h3);
        check("nocall", 32'(taken_cnt), 32'(n));
        do_ret;
        wait_cnt(n + 1);
        check("src", 32'(taken.src), 32'h2);
        do_ret;
        do_ret;
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_ENABLES, 32'h0);
        sleep <= 1'b1;
        pulse(src_evt_t'(10'h001));
        wake_win(1);
        pulse(src_evt_t'(10'h001));
        wake_win(0);
        sleep <= 1'b0;
        foreach (ticks[i]) begin
            bus(1'b1, 8'(OFS_TBC0 + 4 * ticks[i].u), 32'h0);
            bus(1'b1, OFS_FLAGS, 32'h0);
            bus(1'b1, 8'(OFS_PSC0 + 4 * ticks[i].u), 32'(ticks[i].sel));
            bus(1'b1, 8'(OFS_TBC0 + 4 * ticks[i].u), 32'h80 | 32'(ticks[i].code));
            t0 = cyc;
            do bus(1'b0, OFS_FLAGS, 32'h0); while (rd[5 + ticks[i].u] !== 1'b1 && cyc - t0 < 2 * ticks[i].n);
            check("tick", 32'(cyc - t0 >= ticks[i].n - 8 && cyc - t0 <= ticks[i].n + 24), 32'h1);
        end
        bus(1'b1, OFS_TBC0, 32'h0);
        bus(1'b1, OFS_TBC1, 32'h0);
        bus(1'b1, OFS_FLAGS, 32'h0);
        repeat (300) @(posedge core_clk);
        rdchk("idle", OFS_FLAGS, 32'h0);
        // an enabled time base calls in; its service clears its flag and the global enable
        bus(1'b1, OFS_PSC0, 32'h0);
        bus(1'b1, OFS_ENABLES, 32'h20);
        bus(1'b1, OFS_CTRL, 32'h01);
        bus(1'b1, OFS_TBC0, 32'h80);
        wait_cnt(n + 1);
        check("src", 32'(taken.src), 32'h5);
        check("vector", 32'(taken.vector), 32'(VEC_BASE_DEF) + 32'h14);
        rdchk("flags", OFS_FLAGS, 32'h0);
        rdchk("gie", OFS_CTRL, 32'h0);
        test_done;
    end
endmodule // periph_irq_ctrl_tb
`default_nettype wire
